/* logic/arith_exec_pkg.sv */
// package: opcodes, instruction field positions and clock counts for the
// extended arithmetic execution slice.
// assumes one 250 MHz clock; nothing here is device specific beyond encodings.
package arith_exec_pkg;

   // ----------------------------------------------------------------------
   // instruction field layout
   // ----------------------------------------------------------------------
   localparam int OPCODE_MSB  = 31;
   localparam int OPCODE_LSB  = 26;
   localparam int WZ_BIT      = 25;
   localparam int WC_BIT      = 24;
   localparam int WR_BIT      = 23;
   localparam int IMM_BIT     = 22;
   localparam int COND_MSB    = 21;
   localparam int COND_LSB    = 18;
   localparam int DEST_MSB    = 17;
   localparam int DEST_LSB    = 9;
   localparam int SRC_MSB     = 8;
   localparam int SRC_LSB     = 0;
   localparam int ADDR_WIDTH  = 9;
   localparam int DATA_WIDTH  = 32;

   localparam logic [3:0] COND_ALWAYS = 4'hF;

   // ----------------------------------------------------------------------
   // opcodes handled by this slice
   // ----------------------------------------------------------------------
   localparam logic [5:0] OP_NEGATE_UNLESS_ZERO_FLAG     = 6'h2F;
   localparam logic [5:0] OP_COMPARE_SIGNED              = 6'h30;
   localparam logic [5:0] OP_COMPARE_SIGNED_WITH_CARRY   = 6'h31;
   localparam logic [5:0] OP_ADD_WITH_CARRY              = 6'h32;
   localparam logic [5:0] OP_SUBTRACT_WITH_BORROW        = 6'h33;
   localparam logic [5:0] OP_ADD_SIGNED                  = 6'h34;
   localparam logic [5:0] OP_SUBTRACT_SIGNED             = 6'h35;
   localparam logic [5:0] OP_ADD_SIGNED_WITH_CARRY       = 6'h36;
   localparam logic [5:0] OP_SUBTRACT_SIGNED_WITH_BORROW = 6'h37;
   localparam logic [5:0] OP_CONDITIONAL_SUBTRACT        = 6'h38;
   localparam logic [5:0] OP_DECREMENT_BRANCH_NONZERO    = 6'h39;
   localparam logic [5:0] OP_TEST_BRANCH_ON_ZERO         = 6'h3B;

   // ----------------------------------------------------------------------
   // clock counts
   // ----------------------------------------------------------------------
   localparam logic [3:0] BASE_CLOCKS    = 4'h4;
   localparam logic [3:0] NO_JUMP_CLOCKS = 4'h8;
   localparam logic [3:0] COUNT_START    = 4'h1;

   typedef enum logic {ST_IDLE, ST_RUN} exec_state_type;

endpackage

/* logic/arith_unit.sv */
// arith_unit: combinational result and flag logic for one decoded opcode.
// assumes operands are already selected (immediate applied) and held stable.
module arith_unit
(
   input  wire logic [5:0]  opcode,
   input  wire logic [31:0] d_op,
   input  wire logic [31:0] s_op,
   input  wire logic        z_old,
   input  wire logic        c_old,
   output logic [31:0]      result,
   output logic             z_new,
   output logic             c_new,
   output logic             write_allow,
   output logic             is_branch,
   output logic             branch_take,
   output logic             supported
);
   import arith_exec_pkg::*;

   // ----------------------------------------------------------------------
   // shared adders
   // ----------------------------------------------------------------------
   wire logic [32:0] add_u   = {1'b0, d_op} + {1'b0, s_op};
   wire logic [32:0] addc_u  = add_u + {32'h0000_0000, c_old};
   wire logic [32:0] sub_u   = {1'b0, d_op} - {1'b0, s_op};
   wire logic [32:0] subc_u  = sub_u - {32'h0000_0000, c_old};
   wire logic [33:0] d_sx    = {{2{d_op[31]}}, d_op};
   wire logic [33:0] s_sx    = {{2{s_op[31]}}, s_op};
   wire logic [33:0] cin_x   = {33'h0_0000_0000, c_old};
   wire logic [33:0] add_signed_x  = d_sx + s_sx;
   wire logic [33:0] addsc_x = add_signed_x + cin_x;
   wire logic [33:0] subtract_signed_x  = d_sx - s_sx;
   wire logic [33:0] subsc_x = subtract_signed_x - cin_x;
   wire logic [31:0] neg_s   = 32'h0000_0000 - s_op;
   wire logic [31:0] dec_d   = d_op - 32'h0000_0001;
   wire logic        d_ge_s  = !sub_u[32];

   // signed overflow: the 34-bit exact value does not fit in 32 bits
   function automatic logic ovf(input logic [33:0] v);
      ovf = (v[33:31] != 3'h0) && (v[33:31] != 3'h7);
   endfunction

   always_comb begin
      result      = d_op;
      z_new       = z_old;
      c_new       = c_old;
      write_allow = 1'b1;
      is_branch   = 1'b0;
      branch_take = 1'b0;
      supported   = 1'b1;
      case (opcode)
         OP_NEGATE_UNLESS_ZERO_FLAG: begin
            result = z_old ? s_op : neg_s;                    // RQ1
            z_new  = (result == 32'h0000_0000);               // RQ1
            c_new  = s_op[31];                                // RQ1
         end
         OP_COMPARE_SIGNED: begin
            result = sub_u[31:0];
            z_new  = (d_op == s_op);                          // RQ2
            c_new  = subtract_signed_x[33];                              // RQ2
         end
         OP_COMPARE_SIGNED_WITH_CARRY: begin
            result = subc_u[31:0];
            z_new  = z_old && (subc_u[31:0] == 32'h0000_0000); // RQ3
            c_new  = subsc_x[33];                             // RQ3
         end
         OP_ADD_WITH_CARRY: begin
            result = addc_u[31:0];                            // RQ4
            z_new  = z_old && (result == 32'h0000_0000);      // RQ4
            c_new  = addc_u[32];                              // RQ4
         end
         OP_SUBTRACT_WITH_BORROW: begin
            // also the unsigned extended compare, told apart only by write bit
            result = subc_u[31:0];                            // RQ5 RQ6
            z_new  = z_old && (result == 32'h0000_0000);      // RQ5 RQ6
            c_new  = subc_u[32];                              // RQ5 RQ6
         end
         OP_ADD_SIGNED: begin
            result = add_signed_x[31:0];                            // RQ7
            z_new  = (result == 32'h0000_0000);               // RQ7
            c_new  = ovf(add_signed_x);                             // RQ7
         end
         OP_SUBTRACT_SIGNED: begin
            result = subtract_signed_x[31:0];                            // RQ7
            z_new  = (result == 32'h0000_0000);               // RQ7
            c_new  = ovf(subtract_signed_x);                             // RQ7
         end
         OP_ADD_SIGNED_WITH_CARRY: begin
            result = addsc_x[31:0];                           // RQ8
            z_new  = z_old && (result == 32'h0000_0000);      // RQ8
            c_new  = ovf(addsc_x);                            // RQ8
         end
         OP_SUBTRACT_SIGNED_WITH_BORROW: begin
            result = subsc_x[31:0];                           // RQ8
            z_new  = z_old && (result == 32'h0000_0000);      // RQ8
            c_new  = ovf(subsc_x);                            // RQ8
         end
         OP_CONDITIONAL_SUBTRACT: begin
            result      = sub_u[31:0];                        // RQ9
            write_allow = d_ge_s;                             // RQ9
            z_new       = (d_op == s_op);                     // RQ9
            c_new       = d_ge_s;                             // RQ9
         end
         OP_DECREMENT_BRANCH_NONZERO: begin
            result      = dec_d;                              // RQ10
            z_new       = (dec_d == 32'h0000_0000);           // RQ10
            c_new       = (d_op == 32'h0000_0000);            // RQ10
            is_branch   = 1'b1;
            branch_take = (dec_d != 32'h0000_0000);           // RQ10
         end
         OP_TEST_BRANCH_ON_ZERO: begin
            z_new       = (d_op == 32'h0000_0000);            // RQ11
            c_new       = 1'b0;
            is_branch   = 1'b1;
            branch_take = (d_op == 32'h0000_0000);            // RQ11
         end
         default: begin
            write_allow = 1'b0;
            supported   = 1'b0;
         end
      endcase
   end

endmodule

/* logic/core_extended_arith_exec.sv */
// core_extended_arith_exec: multi-cycle execution slice for the extended
// arithmetic, compare and decrement/test branch group of a 32-bit core.
// assumes the sequencer supplies D and S values read from register RAM
// together with the instruction, and the current Z and C flags.
//
// Behaviour
// [RQ1] negate S unless Z; Z zero, C=S31
// [RQ2] signed compare: Z equal, C signed borrow
// [RQ3] signed compare with carry, Z chained
// [RQ4] add with carry, Z chained, unsigned carry
// [RQ5] subtract with borrow, Z chained, unsigned borrow
// [RQ6] unsigned extended compare: same opcode, no write
// [RQ7] signed add/subtract: Z zero, C overflow
// [RQ8] signed add/subtract with carry, Z chained
// [RQ9] subtract only if D >= S unsigned
// [RQ10] decrement, jump if nonzero; 4 or 8 clocks
// [RQ11] test, jump if zero; fall-through 8 clocks
// [RQ12] decode opcode, effects, condition, D, S fields
// [RQ13] flags and D written only when enabled
module core_extended_arith_exec
(
   input  wire logic                             clock,
   input  wire logic                             rst,
   input  wire logic                             start,
   input  wire logic [31:0]                      instr,
   input  wire logic [arith_exec_pkg::DATA_WIDTH-1:0] d_value,
   input  wire logic [arith_exec_pkg::DATA_WIDTH-1:0] s_value,
   input  wire logic                             z_in,
   input  wire logic                             c_in,
   output logic                                  busy,
   output logic                                  done,
   output logic [arith_exec_pkg::DATA_WIDTH-1:0] result_out,
   output logic                                  result_write,
   output logic [arith_exec_pkg::ADDR_WIDTH-1:0] dest_addr,
   output logic                                  z_out,
   output logic                                  z_write,
   output logic                                  c_out,
   output logic                                  c_write,
   output logic                                  jump_take,
   output logic [arith_exec_pkg::ADDR_WIDTH-1:0] jump_addr
);
   import arith_exec_pkg::*;

   // ----------------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------------
   wire logic [5:0]            opcode_in = instr[OPCODE_MSB:OPCODE_LSB];   // RQ12
   wire logic                  wz_in     = instr[WZ_BIT];                  // RQ12
   wire logic                  wc_in     = instr[WC_BIT];                  // RQ12
   wire logic                  wr_in     = instr[WR_BIT];                  // RQ12
   wire logic                  imm_in    = instr[IMM_BIT];                 // RQ12
   wire logic [3:0]            cond_in   = instr[COND_MSB:COND_LSB];       // RQ12
   wire logic [ADDR_WIDTH-1:0] dest_in   = instr[DEST_MSB:DEST_LSB];       // RQ12
   wire logic [ADDR_WIDTH-1:0] src_in    = instr[SRC_MSB:SRC_LSB];         // RQ12

   // condition bits indexed by {C,Z}: bit3 C&Z, bit2 C&!Z, bit1 !C&Z, bit0 !C&!Z
   function automatic logic cond_met(input logic [3:0] cond, input logic c, input logic z);
      cond_met = (cond == COND_ALWAYS) || cond[{c, z}];
   endfunction

   wire logic cond_pass = cond_met(cond_in, c_in, z_in);                      // RQ12
   wire logic [31:0] s_sel = imm_in ? {23'h00_0000, src_in} : s_value;       // RQ12

   // ----------------------------------------------------------------------
   // held instruction state
   // ----------------------------------------------------------------------
   exec_state_type            state_r;
   exec_state_type            state_nxt;
   logic                      busy_r;
   logic [3:0]                cnt_r;
   logic [5:0]                opcode_r;
   logic                      wz_r;
   logic                      wc_r;
   logic                      wr_r;
   logic                      exec_r;
   logic [ADDR_WIDTH-1:0]     dest_r;
   logic [31:0]               d_r;
   logic [31:0]               s_r;
   logic                      z_r;
   logic                      c_r;

   // ----------------------------------------------------------------------
   // request acceptance
   // ----------------------------------------------------------------------
   // a start during a run is dropped; busy is already low in the done cycle
   wire logic accept = start && !busy_r;

   // operands are captured here so the sequencer may move on during the run
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         opcode_r <= 6'h00;
         wz_r     <= 1'b0;
         wc_r     <= 1'b0;
         wr_r     <= 1'b0;
         exec_r   <= 1'b0;
         dest_r   <= 9'h000;
         d_r      <= 32'h0000_0000;
         s_r      <= 32'h0000_0000;
         z_r      <= 1'b0;
         c_r      <= 1'b0;
      end else if (accept) begin
         opcode_r <= opcode_in;
         wz_r     <= wz_in;
         wc_r     <= wc_in;
         wr_r     <= wr_in;
         exec_r   <= cond_pass;
         dest_r   <= dest_in;
         d_r      <= d_value;
         s_r      <= s_sel;
         z_r      <= z_in;
         c_r      <= c_in;
      end
   end

   // ----------------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------------
   logic [31:0] alu_result;
   logic        alu_z;
   logic        alu_c;
   logic        alu_write_allow;
   logic        alu_is_branch;
   logic        alu_branch_take;
   logic        alu_supported;

   // unsupported opcodes still run four clocks and raise done, but no write, flag or jump strobe
   arith_unit u_arith (
      .opcode      (opcode_r),
      .d_op        (d_r),
      .s_op        (s_r),
      .z_old       (z_r),
      .c_old       (c_r),
      .result      (alu_result),
      .z_new       (alu_z),
      .c_new       (alu_c),
      .write_allow (alu_write_allow),
      .is_branch   (alu_is_branch),
      .branch_take (alu_branch_take),
      .supported   (alu_supported)
   );

   // ----------------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------------
   // the count is one after the taking edge, so done follows N-1 edges later
   wire logic       take_jump  = exec_r && alu_is_branch && alu_branch_take;
   wire logic       long_run   = exec_r && alu_is_branch && !alu_branch_take;   // RQ10 RQ11
   wire logic [3:0] total      = long_run ? NO_JUMP_CLOCKS : BASE_CLOCKS;      // RQ10 RQ11
   wire logic       finish     = (state_r == ST_RUN) && (cnt_r == total - 4'h1);
   wire logic       do_write   = exec_r && alu_supported && wr_r && alu_write_allow; // RQ13
   wire logic       do_z       = exec_r && alu_supported && wz_r;              // RQ13
   wire logic       do_c       = exec_r && alu_supported && wc_r;              // RQ13

   // st_run spans every cycle of a run except the done cycle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (accept) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (finish) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         busy_r  <= 1'b0;
         cnt_r   <= 4'h0;
      end else begin
         state_r <= state_nxt;
         busy_r  <= (state_nxt == ST_RUN);
         cnt_r   <= accept ? COUNT_START : cnt_r + 4'h1;
      end
   end

   // ----------------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------------
   // strobes last one cycle; data outputs hold until the next done
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         done         <= 1'b0;
         result_out   <= 32'h0000_0000;
         result_write <= 1'b0;
         dest_addr    <= 9'h000;
         z_out        <= 1'b0;
         z_write      <= 1'b0;
         c_out        <= 1'b0;
         c_write      <= 1'b0;
         jump_take    <= 1'b0;
         jump_addr    <= 9'h000;
      end else begin
         done         <= finish;
         result_write <= finish && do_write;                            // RQ13
         z_write      <= finish && do_z;                                // RQ13
         c_write      <= finish && do_c;                                // RQ13
         jump_take    <= finish && take_jump;                           // RQ10 RQ11
         // an unwritten flag is handed back as sampled
         if (finish) begin
            result_out <= alu_result;
            dest_addr  <= dest_r;
            z_out      <= do_z ? alu_z : z_r;                           // RQ13
            c_out      <= do_c ? alu_c : c_r;                           // RQ13
            jump_addr  <= s_r[ADDR_WIDTH-1:0];
         end
      end
   end

   assign busy = busy_r;

endmodule

/* verif/core_extended_arith_exec_monitor.sv */
// checker: handshake timing and result relations of the execution slice
// assumes it is bound onto core_extended_arith_exec and sees only its ports
module exec_monitor
   import arith_exec_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        start,
   input wire logic [31:0] instr,
   input wire logic [31:0] d_value,
   input wire logic [31:0] s_value,
   input wire logic        z_in,
   input wire logic        c_in,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [31:0] result_out,
   input wire logic        result_write,
   input wire logic [8:0]  dest_addr,
   input wire logic        z_out,
   input wire logic        z_write,
   input wire logic        c_out,
   input wire logic        c_write,
   input wire logic        jump_take,
   input wire logic [8:0]  jump_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // operands captured at the taking edge
   // ---------------------------------------------------------------
   logic [31:0] instr_r;
   logic [31:0] d_r;
   logic [31:0] s_r;
   logic        z_r;
   wire         taken = start && !busy;
   wire  [5:0]  op    = instr_r[OPCODE_MSB:OPCODE_LSB];
   wire  [31:0] s_sel = instr[IMM_BIT] ? {23'h0, instr[SRC_MSB:SRC_LSB]} : s_value;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         instr_r <= 32'h0;
         d_r     <= 32'h0;
         s_r     <= 32'h0;
         z_r     <= 1'h0;
      end else if (taken) begin
         instr_r <= instr;
         d_r     <= d_value;
         s_r     <= s_sel;
         z_r     <= z_in;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_run; taken |=> busy[*3]; endproperty
   a_run: assert property (p_run) else $error("busy shorter than three cycles");
   property p_bound; taken |-> ##[4:8] done; endproperty
   a_bound: assert property (p_bound) else $error("no done within eight cycles");
   property p_wr; result_write |-> done && instr_r[WR_BIT]; endproperty
   a_wr: assert property (p_wr) else $error("result write without enable");
   property p_flags;
      (z_write || c_write) |->
         done && (!z_write || instr_r[WZ_BIT]) && (!c_write || instr_r[WC_BIT]);
   endproperty
   a_flags: assert property (p_flags) else $error("flag strobe without enable");
   property p_dest; done |-> dest_addr == instr_r[DEST_MSB:DEST_LSB]; endproperty
   a_dest: assert property (p_dest) else $error("destination field wrong");
   property p_negate;
      done && result_write && op == OP_NEGATE_UNLESS_ZERO_FLAG |->
         result_out == (z_r ? s_r : 32'h0 - s_r) && (!c_write || c_out == s_r[31]);
   endproperty
   a_negate: assert property (p_negate) else $error("negate result wrong");
   property p_cond_sub;
      done && c_write && op == OP_CONDITIONAL_SUBTRACT |->
         c_out == (d_r >= s_r) && result_write == (instr_r[WR_BIT] && d_r >= s_r);
   endproperty
   a_cond_sub: assert property (p_cond_sub) else $error("conditional subtract wrong");
   property p_jump;
      jump_take |-> done && jump_addr == s_r[8:0] &&
         (op == OP_DECREMENT_BRANCH_NONZERO || op == OP_TEST_BRANCH_ON_ZERO);
   endproperty
   a_jump: assert property (p_jump) else $error("jump strobe wrong");

   c_jump: cover property (done && jump_take);
   c_result: cover property (done && result_write);
   c_quiet: cover property (done && !result_write && !z_write && !c_write);
endmodule

bind core_extended_arith_exec exec_monitor mon (
   .clock(clock), .rst(rst), .start(start), .instr(instr), .d_value(d_value),
   .s_value(s_value), .z_in(z_in), .c_in(c_in), .busy(busy), .done(done),
   .result_out(result_out), .result_write(result_write), .dest_addr(dest_addr),
   .z_out(z_out), .z_write(z_write), .c_out(c_out), .c_write(c_write),
   .jump_take(jump_take), .jump_addr(jump_addr)
);

/* verif/exec_partner.sv */
// partner: register file and flag holder fed by the execution slice strobes
// assumes the bench reads operands from ram and flags before each request
module exec_partner
(
   input wire logic        clock,
   input wire logic        done,
   input wire logic        result_write,
   input wire logic [8:0]  dest_addr,
   input wire logic [31:0] result_out,
   input wire logic        z_write,
   input wire logic        z_out,
   input wire logic        c_write,
   input wire logic        c_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] ram [0:511];
   logic        z_flag;
   logic        c_flag;

   always @(posedge clock) begin
      if (done && result_write) ram[dest_addr] <= result_out;
      if (done && z_write) z_flag <= z_out;
      if (done && c_write) c_flag <= c_out;
   end
endmodule

/* verif/core_extended_arith_exec_tb_top.sv */
// testbench: single instructions through the slice, checking results,
// flags, strobes and clock counts; assumes exec_partner holds the registers
module core_extended_arith_exec_tb_top;
   import arith_exec_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock   = 1'h0;
   logic        rst     = 1'h1;
   logic        start   = 1'h0;
   logic [31:0] instr   = 32'h0;
   logic [31:0] d_value = 32'h0;
   logic [31:0] s_value = 32'h0;
   logic        z_in    = 1'h0;
   logic        c_in    = 1'h0;
   logic        busy, done, result_write, z_out, z_write, c_out, c_write, jump_take;
   logic [31:0] result_out;
   logic [8:0]  dest_addr, jump_addr;
   int          mismatches = 0;
   int          n_tests    = 0;
   int          cycles     = 0;

   always #2 clock = ~clock;

   core_extended_arith_exec DUT (
      .clock(clock), .rst(rst), .start(start), .instr(instr), .d_value(d_value),
      .s_value(s_value), .z_in(z_in), .c_in(c_in), .busy(busy), .done(done),
      .result_out(result_out), .result_write(result_write), .dest_addr(dest_addr),
      .z_out(z_out), .z_write(z_write), .c_out(c_out), .c_write(c_write),
      .jump_take(jump_take), .jump_addr(jump_addr)
   );

   exec_partner m (
      .clock(clock), .done(done), .result_write(result_write), .dest_addr(dest_addr),
      .result_out(result_out), .z_write(z_write), .z_out(z_out), .c_write(c_write),
      .c_out(c_out)
   );

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // D in word 1, S in word 2 or the source field; ex = {exec, wr, z, c, jump}
   task automatic run(input logic [5:0] op, input logic [3:0] eff, input logic [3:0] cond,
                      input logic [31:0] d, input logic [31:0] s, input logic [1:0] zc,
                      input logic [31:0] er, input logic [4:0] ex, input int ncyc);
      int         n;
      logic [8:0] src;
      src = eff[0] ? s[8:0] : 9'h002;
      m.ram[1] = d;
      m.ram[2] = eff[0] ? ~s : s;
      m.z_flag = zc[1];
      m.c_flag = zc[0];
      instr = {op, eff, cond, 9'h001, src};
      d_value = m.ram[1];
      s_value = m.ram[2];
      z_in = m.z_flag;
      c_in = m.c_flag;
      start = 1'h1;
      @(posedge clock);
      #1;
      start = 1'h0;
      n = 1;
      while (done !== 1'h1 && n < 12) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(n, ncyc, "clocks");
      chk(result_write, ex[3], "write strobe");
      chk(z_write, eff[3] & ex[4], "z strobe");
      chk(c_write, eff[2] & ex[4], "c strobe");
      chk(jump_take, ex[0], "jump strobe");
      if (ex[0])
         chk(jump_addr, s[8:0], "jump target");
      @(posedge clock);
      #1;
      chk(m.ram[1], ex[3] ? er : d, "stored D");
      chk(m.z_flag, (eff[3] & ex[4]) ? ex[2] : zc[1], "z flag");
      chk(m.c_flag, (eff[2] & ex[4]) ? ex[1] : zc[0], "c flag");
   endtask

   initial begin
      repeat (3) @(posedge clock);
      #1;
      rst = 1'h0;
      run(6'h2F, 4'hE, 4'hF, 32'h0, 32'h5, 2'h0, 32'hFFFFFFFB, 5'h18, 4);
      run(6'h2F, 4'hE, 4'hF, 32'h0, 32'h80000000, 2'h2, 32'h80000000, 5'h1A, 4);
      run(6'h30, 4'hC, 4'hF, 32'hFFFFFFFF, 32'h1, 2'h0, 32'h0, 5'h12, 4);
      run(6'h30, 4'hC, 4'hF, 32'h5, 32'h5, 2'h0, 32'h0, 5'h14, 4);
      run(6'h31, 4'hC, 4'hF, 32'h6, 32'h5, 2'h3, 32'h0, 5'h14, 4);
      run(6'h31, 4'hC, 4'hF, 32'h6, 32'h5, 2'h1, 32'h0, 5'h10, 4);
      run(6'h32, 4'hE, 4'hF, 32'hFFFFFFFF, 32'h0, 2'h3, 32'h0, 5'h1E, 4);
      run(6'h33, 4'hE, 4'hF, 32'h0, 32'h0, 2'h3, 32'hFFFFFFFF, 5'h1A, 4);
      run(6'h33, 4'hC, 4'hF, 32'h5, 32'h4, 2'h3, 32'h0, 5'h14, 4);
      run(6'h34, 4'hE, 4'hF, 32'h7FFFFFFF, 32'h1, 2'h0, 32'h80000000, 5'h1A, 4);
      run(6'h35, 4'hE, 4'hF, 32'h80000000, 32'h1, 2'h0, 32'h7FFFFFFF, 5'h1A, 4);
      run(6'h36, 4'hE, 4'hF, 32'hFFFFFFFF, 32'h0, 2'h3, 32'h0, 5'h1C, 4);
      run(6'h37, 4'hE, 4'hF, 32'h1, 32'h0, 2'h1, 32'h0, 5'h18, 4);
      run(6'h38, 4'hE, 4'hF, 32'h5, 32'h5, 2'h0, 32'h0, 5'h1E, 4);
      run(6'h38, 4'hE, 4'hF, 32'h4, 32'h5, 2'h0, 32'h0, 5'h10, 4);
      run(6'h39, 4'hF, 4'hF, 32'h2, 32'hAB, 2'h0, 32'h1, 5'h19, 4);
      run(6'h39, 4'hF, 4'hF, 32'h1, 32'hAB, 2'h0, 32'h0, 5'h1C, 8);
      run(6'h39, 4'hF, 4'hF, 32'h0, 32'hAB, 2'h0, 32'hFFFFFFFF, 5'h1B, 4);
      run(6'h3B, 4'hD, 4'hF, 32'h0, 32'hAB, 2'h0, 32'h0, 5'h15, 4);
      run(6'h3B, 4'hD, 4'hF, 32'h3, 32'hAB, 2'h0, 32'h0, 5'h10, 8);
      run(6'h34, 4'hE, 4'h1, 32'h1, 32'h1, 2'h1, 32'h0, 5'h00, 4);
      run(6'h34, 4'hE, 4'h1, 32'h1, 32'h1, 2'h0, 32'h2, 5'h18, 4);
      run(6'h34, 4'h7, 4'hF, 32'h1, 32'hFF, 2'h0, 32'h100, 5'h18, 4);
      run(6'h3A, 4'hE, 4'hF, 32'h1, 32'h1, 2'h0, 32'h0, 5'h00, 4);
      finish_test();
   end
endmodule
